// ---- pkg/acc_pkg.sv ----
// Package for the conversion control block: offsets, fields, channel codes
package acc_pkg;
  localparam int ACC_DW = 8;
  localparam int ACC_AW = 4;
  localparam logic [3:0] ACC_OFS_SCR = 4'h0;
  localparam logic [3:0] ACC_OFS_RH = 4'h4;
  localparam logic [3:0] ACC_OFS_RL = 4'h8;
  localparam logic [3:0] ACC_OFS_CLK = 4'hc;
  localparam logic [3:0] ACC_OFS_CTL = 4'h0;
  // Status/control field positions
  localparam int ACC_SCR_CONV_COMPLETE_FLAG = 7;
  localparam int ACC_SCR_IEN = 6;
  localparam int ACC_SCR_CONT = 5;
  localparam int ACC_CH_W = 5;
  // Clock register field positions
  localparam int ACC_CLK_ASYNC_CLOCK_ENABLE = 7;
  localparam int ACC_CLK_LSMP = 4;
  localparam int ACC_CLK_MODE_LO = 2;
  localparam logic [7:0] ACC_CLK_RST = 8'h00;
  localparam logic [4:0] ACC_CH_OFF = 5'h1f;
  localparam logic [4:0] ACC_CH_EXT_MAX = 5'h05;
  localparam logic [4:0] ACC_CH_BANDGAP = 5'h1a;
  localparam logic [4:0] ACC_CH_VREFH = 5'h1d;
  localparam logic [4:0] ACC_CH_VREFL = 5'h1e;
  localparam logic [1:0] ACC_MODE_8 = 2'h0;
  localparam logic [1:0] ACC_MODE_10 = 2'h1;
  localparam logic [1:0] ACC_MODE_RSV = 2'h2;
  localparam logic [1:0] ACC_MODE_10HW = 2'h3;
  // Sample phase in half converter cycles: 3.5 and 23.5 cycles
  localparam int ACC_SMP_SHORT_HALF = 7;
  localparam int ACC_SMP_LONG_HALF = 47;
  localparam logic [9:0] ACC_RES_ZERO = 10'h000;
  localparam logic [7:0] ACC_BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    ACC_SRC_EXT, ACC_SRC_INT, ACC_SRC_OFF, ACC_SRC_BAD
  } acc_src_t;
  typedef struct packed {
    logic [ACC_CH_W-1:0] channel;
    acc_src_t src;
    logic [2:0] ext_idx;
  } acc_sel_t;
endpackage : acc_pkg

// ---- sim/acc_top_properties.sv ----
// Port assertions for the conversion control block
`timescale 1ns/1ps
module acc_props (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic WB_WE_I,
  input wire logic [0:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic STOP_MODE,
  input wire logic CONV_IRQ,
  input wire logic ANALOG_POWER,
  input wire logic ANALOG_ISOLATE,
  input wire logic SAMPLE_ACTIVE,
  input wire logic [2:0] ANALOG_INPUT_N,
  input wire logic ANALOG_INPUT_EN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic take, scr_wr, async_reg;
  logic [5:0] smp_reg;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_SEL_I[0];
  assign scr_wr = take && WB_WE_I && WB_ADR_I == acc_pkg::ACC_OFS_SCR;
  // Async enable shadowed so stop-mode checks know the clock source
  always_ff @(posedge SYS_CLK) begin
    // A status write mid-sample restarts the phase, so the count restarts
    smp_reg <= (SAMPLE_ACTIVE && !scr_wr) ? smp_reg + 6'h01 : 6'h00;
    if (!NRST) async_reg <= 1'b0;
    else if (take && WB_WE_I && WB_ADR_I == acc_pkg::ACC_OFS_CLK)
      async_reg <= WB_DAT_I[acc_pkg::ACC_CLK_ASYNC_CLOCK_ENABLE];
  end
  property p_start;
    scr_wr && WB_DAT_I[4:0] != acc_pkg::ACC_CH_OFF |=> SAMPLE_ACTIVE;
  endproperty
  a_start: assert property (p_start) else $error("no sample");
  // Aborted samples drop power, so only full ones are measured
  property p_smp;
    $fell(SAMPLE_ACTIVE) && ANALOG_POWER |-> smp_reg inside {6'h07, 6'h2f};
  endproperty
  a_smp: assert property (p_smp) else $error("sample length");
  property p_irq;
    $rose(CONV_IRQ) |-> !ANALOG_POWER || SAMPLE_ACTIVE;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not at end");
  property p_clr;
    scr_wr |=> !CONV_IRQ;
  endproperty
  a_clr: assert property (p_clr) else $error("irq kept");
  property p_rst;
    $rose(NRST) |-> !CONV_IRQ && !ANALOG_POWER && ANALOG_ISOLATE;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle");
  property p_ext;
    ANALOG_INPUT_EN |-> ANALOG_INPUT_N <= 3'h5 && ANALOG_POWER;
  endproperty
  a_ext: assert property (p_ext) else $error("bad input");
  property p_stop;
    $rose(STOP_MODE) && !async_reg |-> ##[1:2] !ANALOG_POWER;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_trig;
    $rose(ANALOG_POWER) |-> $past(scr_wr);
  endproperty
  a_trig: assert property (p_trig) else $error("stray start");
  c_irq: cover property ($rose(CONV_IRQ));
  c_long: cover property ($fell(SAMPLE_ACTIVE) && smp_reg == 6'h2f);
  c_stop: cover property ($rose(STOP_MODE) && !async_reg);
endmodule : acc_props

// ---- sim/tb_top.sv ----
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] O_SCR = acc_pkg::ACC_OFS_SCR;
  localparam logic [3:0] O_RH = acc_pkg::ACC_OFS_RH;
  localparam logic [3:0] O_RL = acc_pkg::ACC_OFS_RL;
  localparam logic [3:0] O_CLK = acc_pkg::ACC_OFS_CLK;
  logic clk, nrst, we, cyc, stb, stop, ack, irq, pwr, iso, smp, inen;
  logic [3:0] adr;
  logic [7:0] dw, dr, rd;
  logic [7:0] held[$];
  logic [2:0] inn;
  logic [4:0] ch;
  logic [31:0] seed = 32'h667f;
  logic [4:0] codes [4] = '{5'h00, 5'h1a, 5'h1d, 5'h1e};
  int mismatches = 0;
  int comparisons = 0;
  // Short core count keeps each conversion near a dozen cycles
  acc_top #(.CONV_CYCLES(2)) dut_u (.SYS_CLK(clk), .NRST(nrst),
    .WB_ADR_I(adr), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_WE_I(we),
    .WB_SEL_I(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .STOP_MODE(stop), .CONV_IRQ(irq), .ANALOG_POWER(pwr),
    .ANALOG_ISOLATE(iso), .SAMPLE_ACTIVE(smp), .ANALOG_INPUT_N(inn),
    .ANALOG_INPUT_EN(inen));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Request held until ack is seen, then one idle cycle
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dw <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    wt(4000);
    mismatches++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, stop} = 4'h0;
    adr = 4'h0;
    dw = 8'h00;
    wt(5);
    nrst <= 1'b1;
    wt(1);
    bus(O_SCR, 1'b0, 8'h00);
    chk(rd, 8'h1f);
    chk({6'h00, irq, iso}, 8'h01);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      ch = (i == 0) ? 5'(seed % 6) : codes[i];
      bus(O_SCR, 1'b1, {3'h2, ch});
      chk({inen, inen ? inn : 3'h0}, {ch <= 5'h05, ch[2:0] & {3{i == 0}}});
      chk({7'h00, smp}, 8'h01);
      wt(16);
      chk({7'h00, irq}, 8'h01);
      bus(O_SCR, 1'b0, 8'h00);
      chk(rd, {3'h6, ch});
      bus(O_RH, 1'b0, 8'h00);
      chk(rd, 8'h00);
      bus(O_RL, 1'b0, 8'h00);
      chk({6'h00, irq, pwr}, 8'h00);
    end
    $display("Test single done");
    bus(O_SCR, 1'b1, 8'h02);
    wt(16);
    bus(O_SCR, 1'b0, 8'h00);
    chk({rd[7], irq}, 2'h2);
    bus(O_SCR, 1'b1, 8'h3f);
    wt(16);
    chk({6'h00, pwr, iso}, 8'h01);
    $display("Test off done");
    bus(O_SCR, 1'b1, 8'h25);
    wt(16);
    bus(O_RL, 1'b0, 8'h00);
    wt(16);
    bus(O_SCR, 1'b0, 8'h00);
    chk(rd, 8'ha5);
    bus(O_CLK, 1'b1, 8'h00);
    wt(16);
    bus(O_RL, 1'b0, 8'h00);
    wt(16);
    bus(O_SCR, 1'b0, 8'h00);
    chk(rd, 8'h25);
    bus(O_SCR, 1'b1, 8'h25);
    stop <= 1'b1;
    wt(3);
    chk({7'h00, pwr}, 8'h00);
    stop <= 1'b0;
    wt(30);
    bus(O_SCR, 1'b0, 8'h00);
    chk(rd, 8'h25);
    $display("Test continuous done");
    bus(O_CLK, 1'b1, 8'h14);
    bus(O_CLK, 1'b0, 8'h00);
    chk(rd, 8'h14);
    bus(O_SCR, 1'b1, 8'h03);
    wt(60);
    bus(O_RL, 1'b0, 8'h00);
    held.push_back(rd);
    bus(O_RH, 1'b0, 8'h00);
    held.push_back(rd);
    chk(rd & 8'hfc, 8'h00);
    bus(O_SCR, 1'b1, 8'h03);
    wt(60);
    bus(O_RH, 1'b0, 8'h00);
    chk(rd, held[1]);
    bus(O_RL, 1'b0, 8'h00);
    chk(rd, held[0]);
    $display("Test interlock done");
    seed = xs(seed);
    bus(4'h2, 1'b1, seed[7:0]);
    bus(4'h2, 1'b0, 8'h00);
    chk({rd[7:1], pwr}, 8'h00);
    $display("Test unmapped done");
    print_verdict();
  end
endmodule : tb_top
bind acc_top acc_props chk_u (.*);

// ---- verilog/acc_top.sv ----
// Conversion control logic with a classic Wishbone register slave
`timescale 1ns/1ps
// What this block does
// - Any status/control write aborts conversion; starts new unless channel all ones.
// - Complete flag sets at each end; clears on control write or low read.
// - With enable set, interrupt at conversion end; dropped on result read or control write.
// - Continuous mode converts back to back, updating results each time the interlock allows.
// - Continuous stops on reset, clock write, control write, stop without async.
// - After such a stop, only a new control write resumes conversions.
// - Single mode: each control write with valid channel starts one conversion.
// - Five-bit channel decode: inputs 0-5, bandgap, refs, low-power code.
// - All-ones channel turns converter off, isolates input, no extra conversion.
// - Converter drops to low power automatically after each single-mode conversion.
// - High result holds upper bits in ten-bit modes, unused bits read zero; all zero in eight-bit mode.
// - Ten-bit mode: high read blocks new results until low read.
// - Eight-bit mode has no interlock between high and low.
// - Unused or reserved channels give an undefined result.
// - Continuous timing exact only with enough bus clock versus converter clock.
// - No hardware trigger input; conversions start only by register write.
// - Two-bit mode field: 8-bit, 10-bit, reserved, 10-bit hardware; reset 8-bit.
// - Sample phase lasts 3.5 or 23.5 converter cycles by long select.
// - Complete flag sets regardless of the interrupt enable.
module acc_top #(
  parameter int CONV_CYCLES = 10,
  parameter logic [9:0] STUB_SEED = 10'h2a5
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [acc_pkg::ACC_AW-1:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  output logic [7:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [0:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic STOP_MODE,
  output logic CONV_IRQ,
  output logic ANALOG_POWER,
  output logic ANALOG_ISOLATE,
  output logic SAMPLE_ACTIVE,
  output logic [2:0] ANALOG_INPUT_N,
  output logic ANALOG_INPUT_EN
);
  // Sequence counter is eight bits and holds twice the core count
  localparam int CONV_MAX = 127;
  if (CONV_CYCLES < 1 || CONV_CYCLES > CONV_MAX) begin : g_bad_cycles
    $error("CONV_CYCLES out of range");
  end
  // A zero seed would lock the stub shift register at zero
  if (STUB_SEED == 10'h000) begin : g_bad_seed
    $error("STUB_SEED must not be zero");
  end
  // Byte-wide bus only; the read mux is built for eight bits
  if (acc_pkg::ACC_DW != 8) begin : g_bad_width
    $error("ACC_DW must be eight");
  end

  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT} acc_state_t;

  // Bus clock stands in for the converter clock; each tick counts one half step
  acc_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] scr_reg;
  logic [7:0] clk_reg;
  logic conv_complete_flag_reg, irq_reg, lock_reg, cont_reg, ack_reg;
  logic [9:0] result_reg, stub_reg;
  acc_pkg::acc_sel_t sel;

  wire bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  wire sel_ok = WB_SEL_I[0];
  wire wr = bus_req && WB_WE_I && sel_ok;
  wire rd = bus_req && !WB_WE_I;
  wire wr_scr = wr && (WB_ADR_I == acc_pkg::ACC_OFS_SCR);
  wire wr_clk = wr && (WB_ADR_I == acc_pkg::ACC_OFS_CLK);
  wire rd_rh = rd && (WB_ADR_I == acc_pkg::ACC_OFS_RH);
  wire rd_rl = rd && (WB_ADR_I == acc_pkg::ACC_OFS_RL);
  wire [4:0] wr_ch = WB_DAT_I[acc_pkg::ACC_CH_W-1:0];
  wire wr_off = (wr_ch == acc_pkg::ACC_CH_OFF);
  wire [4:0] cur_ch = scr_reg[acc_pkg::ACC_CH_W-1:0];
  wire [1:0] mode = clk_reg[acc_pkg::ACC_CLK_MODE_LO+1:
                            acc_pkg::ACC_CLK_MODE_LO];
  wire ten_bit = (mode == acc_pkg::ACC_MODE_10) ||
                 (mode == acc_pkg::ACC_MODE_10HW);
  wire long_smp = clk_reg[acc_pkg::ACC_CLK_LSMP];
  wire async_en = clk_reg[acc_pkg::ACC_CLK_ASYNC_CLOCK_ENABLE];
  wire stop_abort = STOP_MODE && !async_en;
  wire busy = (state_reg != ACC_IDLE);
  wire [7:0] smp_len = long_smp ? 8'(acc_pkg::ACC_SMP_LONG_HALF) :
                       8'(acc_pkg::ACC_SMP_SHORT_HALF);
  wire [7:0] conv_len = 8'(2 * CONV_CYCLES);
  wire conv_done = (state_reg == ACC_CONVERT) && (cnt_reg == 8'h01);
  wire load_ok = !(ten_bit && lock_reg);

  // Channel decode; gaps in the code map fall through to the bad source
  wire ch_ext = (cur_ch <= acc_pkg::ACC_CH_EXT_MAX);
  wire ch_int = (cur_ch == acc_pkg::ACC_CH_BANDGAP) ||
                (cur_ch == acc_pkg::ACC_CH_VREFH) ||
                (cur_ch == acc_pkg::ACC_CH_VREFL);
  wire ch_off = (cur_ch == acc_pkg::ACC_CH_OFF);
  always_comb begin
    sel.channel = cur_ch;
    sel.ext_idx = cur_ch[2:0];
    if (ch_ext) begin
      sel.src = acc_pkg::ACC_SRC_EXT;
    end else if (ch_int) begin
      sel.src = acc_pkg::ACC_SRC_INT;
    end else if (ch_off) begin
      sel.src = acc_pkg::ACC_SRC_OFF;
    end else begin
      sel.src = acc_pkg::ACC_SRC_BAD;
    end
  end

  // Sequencer; a status or clock write always wins over the running conversion
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (wr_scr) begin
      if (wr_off) begin
        state_next = ACC_IDLE;
        cnt_next = 8'h00;
      end else begin
        state_next = ACC_SAMPLE;
        cnt_next = smp_len;
      end
    end else if (wr_clk || stop_abort) begin
      state_next = ACC_IDLE;
      cnt_next = 8'h00;
    end else begin
      case (state_reg)
        ACC_IDLE: begin
          cnt_next = 8'h00;
        end
        ACC_SAMPLE: begin
          if (cnt_reg == 8'h01) begin
            state_next = ACC_CONVERT;
            cnt_next = conv_len;
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        ACC_CONVERT: begin
          if (cnt_reg == 8'h01) begin
            if (cont_reg) begin
              state_next = ACC_SAMPLE;
              cnt_next = smp_len;
            end else begin
              state_next = ACC_IDLE;
              cnt_next = 8'h00;
            end
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        default: begin
          state_next = ACC_IDLE;
          cnt_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_reg <= ACC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Registers written by software; the flag bit is never stored here
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      scr_reg <= {3'h0, acc_pkg::ACC_CH_OFF};
    end else if (wr_scr) begin
      scr_reg <= {1'b0, WB_DAT_I[6:0]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      clk_reg <= acc_pkg::ACC_CLK_RST;
    end else if (wr_clk) begin
      clk_reg <= WB_DAT_I;
    end
  end

  // Continuous mode ends on any halt; only a status write restarts it
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cont_reg <= 1'b0;
    end else if (wr_scr) begin
      cont_reg <= WB_DAT_I[acc_pkg::ACC_SCR_CONT] && !wr_off;
    end else if (wr_clk || stop_abort) begin
      cont_reg <= 1'b0;
    end
  end

  // Flag, interrupt and read interlock; hardware set beats a result-read clear, a status write blocks the set
  wire clr_evt = wr_scr || rd_rl;
  wire irq_clr = wr_scr || rd_rl || rd_rh;
  wire ien = scr_reg[acc_pkg::ACC_SCR_IEN];
  wire conv_end = conv_done && !wr_scr;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      conv_complete_flag_reg <= 1'b0;
    end else if (conv_end) begin
      conv_complete_flag_reg <= 1'b1;
    end else if (clr_evt) begin
      conv_complete_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      irq_reg <= 1'b0;
    end else if (conv_end && ien) begin
      irq_reg <= 1'b1;
    end else if (irq_clr || !ien) begin
      irq_reg <= 1'b0;
    end
  end

  // Lock lives only in ten-bit modes; eight-bit reads never hold results
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      lock_reg <= 1'b0;
    end else if (rd_rl || !ten_bit) begin
      lock_reg <= 1'b0;
    end else if (rd_rh) begin
      lock_reg <= 1'b1;
    end
  end

  // Stub core: pseudo-random value, undefined for bad channels
  // Free-running shift register; its phase at the end, XORed with the channel, is the sample value
  wire [9:0] stub_next = {stub_reg[8:0], stub_reg[9] ^ stub_reg[6]};
  wire [9:0] stub_val = stub_reg ^ {5'h00, cur_ch};
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      stub_reg <= STUB_SEED;
    end else begin
      stub_reg <= stub_next;
    end
  end

  // Results blocked by the lock are dropped, not queued
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      result_reg <= acc_pkg::ACC_RES_ZERO;
    end else if (conv_end && load_ok) begin
      result_reg <= stub_val;
    end
  end

  // Read data; in 8-bit mode the result is the upper eight bits
  wire [7:0] res_hi = ten_bit ? {6'h00, result_reg[9:8]} :
                      acc_pkg::ACC_BYTE_ZERO;
  wire [7:0] res_lo = ten_bit ? result_reg[7:0] : result_reg[9:2];
  wire hit_scr = (WB_ADR_I == acc_pkg::ACC_OFS_SCR);
  wire hit_rh = (WB_ADR_I == acc_pkg::ACC_OFS_RH);
  wire hit_rl = (WB_ADR_I == acc_pkg::ACC_OFS_RL);
  wire hit_clk = (WB_ADR_I == acc_pkg::ACC_OFS_CLK);
  wire [7:0] scr_view = {conv_complete_flag_reg, scr_reg[6:0]};
  // Unmapped offsets read as zero
  wire [7:0] rd_mux =
    hit_scr ? scr_view :
    hit_rh ? res_hi :
    hit_rl ? res_lo :
    hit_clk ? clk_reg :
    acc_pkg::ACC_BYTE_ZERO;

  // Ack follows one cycle after the take; masking with ack stops a retake
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      WB_DAT_O <= acc_pkg::ACC_BYTE_ZERO;
    end else if (rd) begin
      WB_DAT_O <= rd_mux;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign CONV_IRQ = irq_reg;
  // Power only while converting; hardware trigger mode has no trigger pin
  assign ANALOG_POWER = busy;
  wire src_off = (sel.src == acc_pkg::ACC_SRC_OFF);
  wire src_ext = (sel.src == acc_pkg::ACC_SRC_EXT);
  assign ANALOG_ISOLATE = src_off;
  assign SAMPLE_ACTIVE = (state_reg == ACC_SAMPLE);
  // Input index is driven always; only the enable gates the pad switch
  assign ANALOG_INPUT_N = sel.ext_idx;
  assign ANALOG_INPUT_EN = busy && src_ext;
endmodule : acc_top
